// file: rtl/scr_readout.sv
// Overview of operation
// [R1] P-W symbol shifted out per host clock
// [R2] Host clocks P-W after frame clock falls
// [R3] Host reads 80 Q bits after good CRC
// [R4] Q bits feed register and CRC checker
// [R5] Good 96-bit block loads 80 bits, flag
// [R6] High Q output marks fresh checked data
// [R7] Bits reversed within each byte, LSB first
// [R8] Q clock low holds one-shot in reset
// [R9] Active one-shot blocks all output loads; code gates only the Q register and Q pin loads, not the P-W load or CRC flag
// [R10] Meter register chains behind Q bits
// [R11] Ring shorts depend on meter mode
// [R12] Level readout clears; peak readout keeps
// [R13] Host gives 96 clocks in peak mode
// [R14] Peak mode stores time of peak
// [R15] Jitter reported as 8-bit unsigned value
// [R16] Frame sync good when timing matches
// [R17] Lock rises on high, falls after eight lows
// [R18] Wide lock needs eight equal samples
// [R19] Velocity reported in wide CAV mode
// [R20] Emphasis flag follows disc emphasis
// [R21] C1 status as 3-bit code
// [R22] C2 status as 3-bit code
// [R23] Q output advances on rising Q clock
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`include "scr_defs.svh"
`default_nettype none
module scr_readout #(
    parameter int MONO_CYCLES = `SCR_MONO_CYCLES, // One-shot length
    parameter int LOCK_CYCLES = `SCR_LOCK_CYCLES, // Lock sample period
    parameter int METER_W = 16 // Meter word width
) (
    input wire logic MCLK, // System clock
    input wire logic SYS_RST, // Async reset, high
    input wire logic [4:0] AVS_ADDRESS, // Byte address
    input wire logic AVS_READ, // Read request
    input wire logic AVS_WRITE, // Write request
    input wire logic [31:0] AVS_WRITEDATA, // Write data
    input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes
    output logic [31:0] AVS_READDATA, // Read data
    output logic AVS_WAITREQUEST, // Stall
    input wire logic PW_SUBCODE_SHIFT_CLOCK, // Host P-W clock pin
    input wire logic Q_SUBCODE_SHIFT_CLOCK, // Host Q clock pin
    input wire logic WRITE_FRAME_CLOCK, // Core frame clock
    input wire logic [7:0] PW_SYMBOL, // Current P-W symbol
    input wire scr_pkg::scr_q_in_t Q_IN, // Sub-Q stream
    input wire logic FRAME_SYNC_DETECT, // Sync found
    input wire logic INSERT_TIMING, // Protection window
    input wire scr_pkg::scr_status_t STATUS_IN, // Status words
    input wire logic [METER_W-1:0] AUDIO_LEVEL, // Abs level
    input wire logic AUDIO_VALID, // Level strobe
    output logic PW_SUBCODE_SERIAL_OUT, // P-W serial data
    output logic Q_SUBCODE_SERIAL_OUT, // Q serial data
    output logic SUBCODE_SYNC_INDICATION, // Block sync
    output logic CRC_GOOD_FLAG, // Last block CRC good
    output logic FRAME_SYNC_GOOD_FLAG, // Frame sync good
    output logic LOCK_FLAG, // Lock
    output logic WIDE_MODE_LOCK_FLAG, // Wide lock
    output logic EMPHASIS_FLAG // Emphasis
);
    localparam int OUT_W = 80 + METER_W; // Chained register width

    // Pin synchronisers and edge history
    logic pw_subcode_shift_clock_s1_q, pw_subcode_shift_clock_s2_q, pw_subcode_shift_clock_s3_q;
    logic q_subcode_shift_clock_s1_q, q_subcode_shift_clock_s2_q, q_subcode_shift_clock_s3_q;
    logic write_frame_clock_q;

    // P-W shifter
    logic [7:0] pw_sr_q;
    logic pw_out_q;

    // Sub-Q collection and CRC
    logic [79:0] sp_q; // Serial/parallel register
    logic [15:0] crc_rx_q; // Received check bits
    logic [15:0] crc_q; // Running remainder
    logic [6:0] qcnt_q; // Bits of current block
    logic crc_flag_q;
    logic subcode_sync_indication_q;

    // One-shot and output register
    logic [15:0] mono_q; // Cycles since Q clock low
    logic [OUT_W-1:0] ps_q; // Parallel/serial register
    logic q_subcode_serial_out_q;

    // Meter state
    logic [METER_W-1:0] meter_q; // Level or peak value
    logic [79:0] peak_time_q; // Time snapshot at peak
    logic [79:0] last_q_q; // Last good Q block

    // Status flags
    logic gfs_q, lock_q, wide_mode_lock_flag_q, emphasis_flag_q;
    logic [2:0] low_run_q, high_run_q;
    logic [16:0] tick_cnt_q;

    // Bus side registers
    logic [3:0] ctrl_q;
    logic wait_q;
    logic [31:0] rdata_q;

    // Edge detection on synced host pins; frame clock fall from raw input
    wire pw_subcode_shift_clock_rise = pw_subcode_shift_clock_s2_q & ~pw_subcode_shift_clock_s3_q;
    wire q_subcode_shift_clock_rise = q_subcode_shift_clock_s2_q & ~q_subcode_shift_clock_s3_q;
    wire write_frame_clock_fall = write_frame_clock_q & ~WRITE_FRAME_CLOCK;

    // Mode decode
    wire [2:0] mode_bits = ctrl_q[`SCR_CTRL_MODE_MSB:`SCR_CTRL_MODE_LSB];
    wire peak_mode = mode_bits == scr_pkg::SCR_METER_PEAK;
    wire level_mode = mode_bits == scr_pkg::SCR_METER_LEVEL;
    wire cavw_mode = ctrl_q[`SCR_CTRL_CAVW_BIT];
    wire ring1_short = peak_mode | level_mode; // see [R11]
    wire ring2_short = peak_mode; // see [R11]

    // One-shot: busy while Q clock recently low
    wire mono_busy = ~q_subcode_shift_clock_s2_q || // see [R8]
        (mono_q < 16'(MONO_CYCLES)); // see [R9]

    // CRC step for one incoming bit
    wire crc_fb = crc_q[15] ^ Q_IN.bit_val;
    wire [15:0] crc_next = {crc_q[14:0], 1'b0} ^
        (crc_fb ? `SCR_CRC_POLY : 16'h0000);
    wire q_take = Q_IN.bit_valid && (qcnt_q < `SCR_Q_BLOCK_BITS);
    wire q_last = q_take && (qcnt_q == `SCR_Q_BLOCK_BITS - 7'h01);
    wire [15:0] rx_full = {crc_rx_q[14:0], Q_IN.bit_val};
    wire blk_ok = q_last && (crc_q == ~rx_full); // see [R5]
    wire [79:0] sp_full = {sp_q[78:0], Q_IN.bit_val};

    // Byte-wise bit reversal of the collected block
    logic [79:0] rev_now; // From the fresh block
    logic [79:0] rev_time; // From the peak snapshot
    genvar gi;
    generate
        for (gi = 0; gi < 80; gi++) begin : g_rev
            localparam int SRC = 72 - 8 * (gi / 8) + (gi % 8);
            assign rev_now[gi] = sp_q[SRC]; // see [R7]
            assign rev_time[gi] = peak_time_q[SRC]; // see [R7]
        end
    endgenerate

    // Load happens only when a good block ends and one-shot idle
    wire do_load = blk_ok && !mono_busy; // see [R9]
    wire [79:0] q_image = peak_mode ? rev_time : rev_now; // see [R14]
    wire [METER_W-1:0] meter_image = ring1_short ? meter_q : '0;
    wire ps_in = ring1_short ? ps_q[0] : 1'b0; // see [R11]
    wire new_peak = AUDIO_VALID && (AUDIO_LEVEL > meter_q);

    // Lock sampling
    wire tick = tick_cnt_q == 17'(LOCK_CYCLES - 1);

    // Avalon decode
    wire req = AVS_READ | AVS_WRITE;
    wire wr_ctrl = AVS_WRITE && !wait_q &&
        (AVS_ADDRESS == `SCR_OFS_CTRL) && AVS_BYTEENABLE[0];
    logic [31:0] rd_mux;
    assign rd_mux =
        (AVS_ADDRESS == `SCR_OFS_CTRL) ? {28'h0000_000, ctrl_q} :
        (AVS_ADDRESS == `SCR_OFS_STATUS) ? {25'h000_0000, mono_busy,
            emphasis_flag_q, STATUS_IN.focus_ok, wide_mode_lock_flag_q, lock_q, gfs_q,
            crc_flag_q} :
        (AVS_ADDRESS == `SCR_OFS_ERRS) ? {18'h0_0000,
            STATUS_IN.c2_code, // see [R22]
            STATUS_IN.c1_code, // see [R21]
            STATUS_IN.jitter} : // see [R15]
        (AVS_ADDRESS == `SCR_OFS_VELOCITY) ? {22'h00_0000,
            cavw_mode ? STATUS_IN.velocity : 10'h000} : // see [R19]
        (AVS_ADDRESS == `SCR_OFS_METER) ? 32'(meter_q) :
        32'h0000_0000;

    // Two-stage synchronisers for host clock pins
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pw_subcode_shift_clock_s1_q <= 1'b0;
            pw_subcode_shift_clock_s2_q <= 1'b0;
            pw_subcode_shift_clock_s3_q <= 1'b0;
            q_subcode_shift_clock_s1_q <= 1'b1;
            q_subcode_shift_clock_s2_q <= 1'b1;
            q_subcode_shift_clock_s3_q <= 1'b1;
            write_frame_clock_q <= 1'b0;
        end else begin
            pw_subcode_shift_clock_s1_q <= PW_SUBCODE_SHIFT_CLOCK;
            pw_subcode_shift_clock_s2_q <= pw_subcode_shift_clock_s1_q;
            pw_subcode_shift_clock_s3_q <= pw_subcode_shift_clock_s2_q;
            q_subcode_shift_clock_s1_q <= Q_SUBCODE_SHIFT_CLOCK;
            q_subcode_shift_clock_s2_q <= q_subcode_shift_clock_s1_q;
            q_subcode_shift_clock_s3_q <= q_subcode_shift_clock_s2_q;
            write_frame_clock_q <= WRITE_FRAME_CLOCK;
        end
    end

    // P-W symbol: loaded at frame clock fall, shifted per host clock
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pw_sr_q <= 8'h00;
            pw_out_q <= 1'b0;
        end else if (write_frame_clock_fall) begin
            pw_sr_q <= {PW_SYMBOL[6:0], 1'b0}; // see [R2]
            pw_out_q <= PW_SYMBOL[7];
        end else if (pw_subcode_shift_clock_rise) begin
            pw_out_q <= pw_sr_q[7]; // see [R1]
            pw_sr_q <= {pw_sr_q[6:0], 1'b0};
        end
    end

    // Sub-Q bit counter, collection and CRC
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            qcnt_q <= 7'h00;
            crc_q <= `SCR_CRC_INIT;
            sp_q <= '0;
            crc_rx_q <= 16'h0000;
        end else if (Q_IN.block_start) begin
            qcnt_q <= 7'h00;
            crc_q <= `SCR_CRC_INIT;
        end else if (q_take) begin
            qcnt_q <= qcnt_q + 7'h01;
            if (qcnt_q < `SCR_Q_DATA_BITS) begin
                sp_q <= sp_full; // see [R4]
                crc_q <= crc_next; // see [R4]
            end else begin
                crc_rx_q <= rx_full;
            end
        end
    end

    // Sync indication and CRC-good flag, updated per block
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            subcode_sync_indication_q <= 1'b0;
            crc_flag_q <= 1'b0;
            last_q_q <= '0;
        end else begin
            subcode_sync_indication_q <= Q_IN.block_start;
            if (q_last) begin
                crc_flag_q <= blk_ok; // see [R5]
            end
            if (blk_ok) begin
                last_q_q <= sp_q; // Data bits only, check bits excluded
            end
        end
    end

    // One-shot counter: cleared while Q clock low, saturates
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mono_q <= 16'hFFFF;
        end else if (!q_subcode_shift_clock_s2_q) begin
            mono_q <= 16'h0000; // see [R8]
        end else if (mono_q != 16'hFFFF) begin
            mono_q <= mono_q + 16'h0001;
        end
    end

    // Parallel/serial output register with meter chained behind
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ps_q <= '0;
        end else if (do_load) begin
            ps_q <= {meter_image, q_image}; // see [R5] [R10]
        end else if (q_subcode_shift_clock_rise) begin
            ps_q <= {ps_in, ps_q[OUT_W-1:1]}; // see [R23]
        end
    end

    // Q pin: flag while idle, current bit while host reads
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q_subcode_serial_out_q <= 1'b0;
        end else if (do_load) begin
            q_subcode_serial_out_q <= 1'b1; // see [R6]
        end else if (mono_busy) begin
            q_subcode_serial_out_q <= q_subcode_shift_clock_rise ? ps_q[1] : ps_q[0]; // see [R23]
        end else begin
            q_subcode_serial_out_q <= crc_flag_q; // see [R6]
        end
    end

    // Meter: level cleared by readout load, peak kept with its time
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            meter_q <= '0;
            peak_time_q <= '0;
        end else if (!ring1_short) begin
            meter_q <= '0;
        end else if (do_load && !ring2_short) begin
            meter_q <= '0; // see [R12]
        end else if (new_peak) begin
            meter_q <= AUDIO_LEVEL; // see [R12]
            if (peak_mode) begin
                peak_time_q <= last_q_q; // see [R14]
            end
        end
    end

    // Frame sync good and lock sampling at the sample rate
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gfs_q <= 1'b0;
            tick_cnt_q <= 17'h0_0000;
        end else begin
            gfs_q <= FRAME_SYNC_DETECT & INSERT_TIMING; // see [R16]
            tick_cnt_q <= tick ? 17'h0_0000 : tick_cnt_q + 17'h0_0001;
        end
    end

    // Run counters of equal samples
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            low_run_q <= 3'h0;
            high_run_q <= 3'h0;
        end else if (tick) begin
            if (gfs_q) begin
                low_run_q <= 3'h0;
                if (high_run_q != `SCR_LOCK_RUN) begin
                    high_run_q <= high_run_q + 3'h1;
                end
            end else begin
                high_run_q <= 3'h0;
                if (low_run_q != `SCR_LOCK_RUN) begin
                    low_run_q <= low_run_q + 3'h1;
                end
            end
        end
    end

    // Lock flags from the sampled runs
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lock_q <= 1'b0;
            wide_mode_lock_flag_q <= 1'b0;
        end else if (tick) begin
            if (gfs_q) begin
                lock_q <= 1'b1; // see [R17]
            end else if (low_run_q == `SCR_LOCK_RUN) begin
                lock_q <= 1'b0; // see [R17]
            end
            if (gfs_q && high_run_q == `SCR_LOCK_RUN) begin
                wide_mode_lock_flag_q <= 1'b1; // see [R18]
            end else if (!gfs_q && low_run_q == `SCR_LOCK_RUN) begin
                wide_mode_lock_flag_q <= 1'b0; // see [R18]
            end
        end
    end

    // Emphasis flag
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            emphasis_flag_q <= 1'b0;
        end else begin
            emphasis_flag_q <= STATUS_IN.emphasis; // see [R20]
        end
    end

    // Avalon slave: one wait cycle, then answer
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= !(req && wait_q);
            if (AVS_READ && wait_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Control register
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_q <= `SCR_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= AVS_WRITEDATA[3:0];
        end
    end

    // Output drive, all straight from flip-flops
    assign PW_SUBCODE_SERIAL_OUT = pw_out_q;
    assign Q_SUBCODE_SERIAL_OUT = q_subcode_serial_out_q;
    assign SUBCODE_SYNC_INDICATION = subcode_sync_indication_q;
    assign CRC_GOOD_FLAG = crc_flag_q;
    assign FRAME_SYNC_GOOD_FLAG = gfs_q;
    assign LOCK_FLAG = lock_q;
    assign WIDE_MODE_LOCK_FLAG = wide_mode_lock_flag_q;
    assign EMPHASIS_FLAG = emphasis_flag_q;
    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
endmodule
`default_nettype wire

// file: rtl/scr_defs.svh
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// Register byte offsets
`define SCR_OFS_CTRL 5'h00
`define SCR_OFS_STATUS 5'h04
`define SCR_OFS_ERRS 5'h08
`define SCR_OFS_VELOCITY 5'h0C
`define SCR_OFS_METER 5'h10

// Control register fields and reset value
`define SCR_CTRL_MODE_LSB 0
`define SCR_CTRL_MODE_MSB 2
`define SCR_CTRL_CAVW_BIT 3
`define SCR_CTRL_RESET 4'h1

// Status register bit positions
`define SCR_ST_CRC_BIT 0
`define SCR_ST_GFS_BIT 1
`define SCR_ST_LOCK_BIT 2
`define SCR_ST_WIDE_MODE_LOCK_FLAG_BIT 3
`define SCR_ST_FOK_BIT 4
`define SCR_ST_EMPHASIS_FLAG_BIT 5
`define SCR_ST_MONO_BIT 6

// Error-status register field positions
`define SCR_ERR_JIT_LSB 0
`define SCR_ERR_C1_LSB 8
`define SCR_ERR_C2_LSB 11

// Sub-Q block framing
`define SCR_Q_BLOCK_BITS 7'h60
`define SCR_Q_DATA_BITS 7'h50
`define SCR_CRC_POLY 16'h1021
`define SCR_CRC_INIT 16'h0000

// Timing
`define SCR_CLK_PERIOD_NS 20
`define SCR_MONO_TIME_NS 270000
`define SCR_MONO_CYCLES \
    ((`SCR_MONO_TIME_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)
`define SCR_LOCK_SAMPLE_NS 2173913
`define SCR_LOCK_CYCLES (`SCR_LOCK_SAMPLE_NS / `SCR_CLK_PERIOD_NS)
`define SCR_LOCK_RUN 3'h7

`endif

// file: rtl/scr_pkg.sv
`default_nettype none
package scr_pkg;
    // Meter modes, one-hot
    typedef enum logic [2:0] {
        SCR_METER_OFF = 3'b001,
        SCR_METER_LEVEL = 3'b010,
        SCR_METER_PEAK = 3'b100
    } scr_meter_t;

    // Sub-Q bit stream from the demodulator
    typedef struct packed {
        logic block_start;
        logic bit_valid;
        logic bit_val;
    } scr_q_in_t;

    // Playback status words from the core
    typedef struct packed {
        logic [7:0] jitter;
        logic [2:0] c1_code;
        logic [2:0] c2_code;
        logic [9:0] velocity;
        logic focus_ok;
        logic emphasis;
    } scr_status_t;
endpackage
`default_nettype wire

// file: tb/scr_readout_monitor.sv
`default_nettype none
module scr_readout_monitor #(
    parameter int LOCK_CYCLES = 10 // Lock sample period
) (
    input wire logic MCLK, // Clock
    input wire logic SYS_RST, // Reset
    input wire logic [4:0] AVS_ADDRESS, // Address
    input wire logic AVS_READ, // Read
    input wire logic AVS_WRITE, // Write
    input wire logic [31:0] AVS_READDATA, // Read data
    input wire logic AVS_WAITREQUEST, // Stall
    input wire logic Q_SUBCODE_SHIFT_CLOCK, // Q clock pin
    input wire logic Q_SUBCODE_SERIAL_OUT, // Q data pin
    input wire scr_pkg::scr_q_in_t Q_IN, // Sub-Q stream
    input wire scr_pkg::scr_status_t STATUS_IN, // Status words
    input wire logic FRAME_SYNC_DETECT, // Sync found
    input wire logic INSERT_TIMING, // Protection window
    input wire logic SUBCODE_SYNC_INDICATION, // Block sync
    input wire logic CRC_GOOD_FLAG, // CRC flag
    input wire logic FRAME_SYNC_GOOD_FLAG, // Frame sync good
    input wire logic LOCK_FLAG, // Lock
    input wire logic WIDE_MODE_LOCK_FLAG, // Wide lock
    input wire logic EMPHASIS_FLAG // Emphasis
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    int hi_n; // Cycles sync good has been high
    int lo_n; // Cycles sync good has been low
    // Run lengths of the frame sync good flag
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            hi_n <= 0;
            lo_n <= 0;
        end else begin
            hi_n <= FRAME_SYNC_GOOD_FLAG ? hi_n + 1 : 0;
            lo_n <= FRAME_SYNC_GOOD_FLAG ? 0 : lo_n + 1;
        end
    end
    bus_wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("bus answer late");
    wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    hole_zero_a: assert property (AVS_READ && AVS_WAITREQUEST &&
        AVS_ADDRESS > 5'h10 |=> AVS_READDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    sync_copy_a: assert property (!$past(SYS_RST) |->
        SUBCODE_SYNC_INDICATION == $past(Q_IN.block_start))
        else $error("block sync wrong");
    gfs_follow_a: assert property (!$past(SYS_RST) |->
        FRAME_SYNC_GOOD_FLAG == $past(FRAME_SYNC_DETECT & INSERT_TIMING))
        else $error("frame sync good wrong");
    crc_at_bit_a: assert property ($changed(CRC_GOOD_FLAG) |->
        $past(Q_IN.bit_valid)) else $error("crc flag moved off a bit");
    qout_frozen_a: assert property (!Q_SUBCODE_SHIFT_CLOCK [*4] ##1
        Q_SUBCODE_SHIFT_CLOCK |-> $stable(Q_SUBCODE_SERIAL_OUT))
        else $error("q out moved");
    emphasis_flag_track_a: assert property (
        $stable(STATUS_IN.emphasis) [*3] |->
        EMPHASIS_FLAG == STATUS_IN.emphasis)
        else $error("emphasis flag wrong");
    lock_fall_a: assert property ($fell(LOCK_FLAG) |->
        lo_n >= 7 * LOCK_CYCLES - 2) else $error("lock fell early");
    wide_rise_a: assert property ($rose(WIDE_MODE_LOCK_FLAG) |->
        hi_n >= 7 * LOCK_CYCLES - 2) else $error("wide lock rose early");
    cover property ($rose(CRC_GOOD_FLAG));
    cover property ($fell(LOCK_FLAG));
    cover property ($rose(WIDE_MODE_LOCK_FLAG));
endmodule
bind scr_readout scr_readout_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) mon (.*);
`default_nettype wire

// file: tb/scr_host.sv
`default_nettype none
module scr_host (
    output logic q_ck, // Q shift clock, idles high
    output logic pw_ck, // P-W shift clock, idles low
    input wire logic q_do, // Q serial data
    input wire logic pw_do // P-W serial data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels of both clocks
    initial begin
        q_ck = 1'b1;
        pw_ck = 1'b0;
    end
    // Clock n bits in at 160 ns, first bit into v[0]
    task automatic shift(input logic sel, input int n,
            output logic [95:0] v);
        v = '0;
        #5; // Keep pin edges clear of the system clock edges
        for (int k = 0; k < n; k++) begin
            if (sel) q_ck = 1'b0;
            else pw_ck = 1'b0;
            #80;
            if (sel) q_ck = 1'b1; // Rise moves to next bit
            else pw_ck = 1'b1;
            #20;
            v[k] = sel ? q_do : pw_do; // Bit shown before the rise
            #60;
        end
        pw_ck = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/scr_readout_tb.sv
`default_nettype none
module scr_readout_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MONO = 50; // Short one-shot
    localparam int LOCKC = 10; // Short lock sample period
    logic MCLK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
    logic [4:0] AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
    logic [3:0] AVS_BYTEENABLE;
    logic WRITE_FRAME_CLOCK, FRAME_SYNC_DETECT, INSERT_TIMING;
    logic AUDIO_VALID, PW_SUBCODE_SERIAL_OUT, Q_SUBCODE_SERIAL_OUT;
    logic SUBCODE_SYNC_INDICATION, CRC_GOOD_FLAG, FRAME_SYNC_GOOD_FLAG;
    logic LOCK_FLAG, WIDE_MODE_LOCK_FLAG, EMPHASIS_FLAG;
    logic [7:0] PW_SYMBOL, s;
    logic [15:0] AUDIO_LEVEL;
    scr_pkg::scr_q_in_t Q_IN;
    scr_pkg::scr_status_t STATUS_IN, st;
    wire PW_SUBCODE_SHIFT_CLOCK, Q_SUBCODE_SHIFT_CLOCK;
    logic [95:0] v;
    logic [15:0] m; // Meter value read back
    logic aud_on; // Gates the random audio strobe
    logic [79:0] d, d2;
    int err_total, n_tests;
    scr_readout #(.MONO_CYCLES(MONO), .LOCK_CYCLES(LOCKC)) DUT (.*);
    scr_host host (.q_ck(Q_SUBCODE_SHIFT_CLOCK),
        .pw_ck(PW_SUBCODE_SHIFT_CLOCK), .q_do(Q_SUBCODE_SERIAL_OUT),
        .pw_do(PW_SUBCODE_SERIAL_OUT));
    // Clock
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    // Random audio levels feed the meter
    always @(posedge MCLK) begin
        AUDIO_VALID <= aud_on & 1'($urandom);
        AUDIO_LEVEL <= 16'($urandom);
    end
    // Compare and count
    task automatic chk(input string nm, input logic [79:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One Avalon access; waits for waitrequest low
    task automatic bus(input logic w, input logic [4:0] a,
            input logic [31:0] wd);
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= wd;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge MCLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    // Serial CRC of the data bits, first bit first
    function automatic logic [15:0] crc16(input logic [79:0] x);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 79; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ x[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    // Serial order seen at the Q pin: bytes kept, bits reversed
    function automatic logic [79:0] qexp(input logic [79:0] x);
        for (int k = 0; k < 80; k++)
            qexp[k] = x[79 - 8 * (k / 8) - (7 - k % 8)];
    endfunction
    // Send one 96-bit block, good or bad check word
    task automatic send_q(input logic [79:0] x, input logic good);
        logic [95:0] b;
        b = {x, good ? ~crc16(x) : crc16(x)};
        @(posedge MCLK);
        Q_IN <= 3'b100;
        for (int k = 95; k >= 0; k--) begin
            @(posedge MCLK);
            Q_IN <= {2'b01, b[k]};
            @(posedge MCLK);
            Q_IN <= 3'b000;
        end
        repeat (4) @(posedge MCLK);
    endtask
    // Verdict
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #400_000;
        err_total++;
        wrap_up();
    end
    // Main sequence
    initial begin
        void'($urandom(61));
        {SYS_RST, AVS_READ, AVS_WRITE, WRITE_FRAME_CLOCK} = 4'h8;
        {FRAME_SYNC_DETECT, INSERT_TIMING, aud_on} = 3'h1;
        {AVS_ADDRESS, AVS_WRITEDATA, PW_SYMBOL} = '0;
        {Q_IN, STATUS_IN, AVS_BYTEENABLE} = 4'hF;
        {err_total, n_tests} = 0;
        repeat (4) @(posedge MCLK);
        SYS_RST <= 1'b0;
        bus(0, 5'h00, 0);
        chk("ctrl reset", rd, 32'h0000_0001);
        bus(0, 5'h14, 0);
        chk("unmapped", rd, 32'h0000_0000);
        bus(1, 5'h00, 32'h0000_0008);
        for (int i = 0; i < 8; i++) begin
            st = scr_pkg::scr_status_t'($urandom);
            st.c1_code = 3'(i);
            st.c2_code = 3'(7 - i);
            STATUS_IN <= st;
            repeat (3) @(posedge MCLK);
            bus(0, 5'h08, 0);
            chk("errs", rd, {st.c2_code, st.c1_code, st.jitter});
            bus(0, 5'h0C, 0);
            chk("velocity", rd, st.velocity);
            bus(0, 5'h04, 0);
            chk("status", rd[5:4], {st.emphasis, st.focus_ok});
        end
        bus(1, 5'h00, 32'h0000_0001);
        bus(0, 5'h0C, 0);
        chk("velocity off", rd, 0);
        $display("test registers done");
        d = {$urandom, $urandom, 16'($urandom)};
        d2 = ~d;
        send_q(d, 1);
        chk("crc good", CRC_GOOD_FLAG, 1);
        chk("q ready", Q_SUBCODE_SERIAL_OUT, 1);
        fork
            host.shift(1, 80, v);
            begin
                repeat (20) @(posedge MCLK);
                send_q(d2, 1);
            end
        join
        chk("q read", v[79:0], qexp(d));
        repeat (MONO + 10) @(posedge MCLK);
        send_q(d2 ^ 80'h5, 1);
        host.shift(1, 80, v);
        chk("q reload", v[79:0], qexp(d2 ^ 80'h5));
        repeat (MONO + 10) @(posedge MCLK);
        send_q(d, 0);
        chk("crc bad", CRC_GOOD_FLAG, 0);
        chk("q bad", Q_SUBCODE_SERIAL_OUT, 0);
        $display("test q readout done");
        // Peak mode: meter frozen, image is the block at the peak
        bus(1, 5'h00, 32'h0000_0004);
        repeat (20) @(posedge MCLK);
        aud_on <= 1'b0;
        repeat (2) @(posedge MCLK);
        bus(0, 5'h10, 0);
        m = rd[15:0];
        send_q(d, 1);
        host.shift(1, 96, v);
        chk("peak q", v[79:0], qexp(d2 ^ 80'h5));
        chk("peak meter", v[95:80], m);
        bus(0, 5'h10, 0);
        chk("peak kept", rd, m);
        repeat (MONO + 10) @(posedge MCLK);
        // Level mode: fresh block, meter cleared by the load
        bus(1, 5'h00, 32'h0000_0002);
        send_q(d, 1);
        host.shift(1, 96, v);
        chk("level q", v[79:0], qexp(d));
        chk("level meter", v[95:80], m);
        bus(0, 5'h10, 0);
        chk("level clear", rd, 0);
        $display("test meter done");
        for (int i = 0; i < 4; i++) begin
            s = 8'($urandom);
            @(posedge MCLK);
            PW_SYMBOL <= s;
            WRITE_FRAME_CLOCK <= 1'b1;
            @(posedge MCLK);
            WRITE_FRAME_CLOCK <= 1'b0;
            repeat (3) @(posedge MCLK);
            host.shift(0, 8, v);
            chk("pw symbol", v[7:0], {<<{s}});
        end
        $display("test p-w readout done");
        for (int i = 0; i < 4; i++) begin
            @(posedge MCLK);
            {FRAME_SYNC_DETECT, INSERT_TIMING} <= 2'(i);
            repeat (3) @(posedge MCLK);
            chk("gfs", FRAME_SYNC_GOOD_FLAG, i == 3);
        end
        repeat (3 * LOCKC) @(posedge MCLK);
        chk("lock up", LOCK_FLAG, 1);
        chk("wide early", WIDE_MODE_LOCK_FLAG, 0);
        repeat (10 * LOCKC) @(posedge MCLK);
        chk("wide up", WIDE_MODE_LOCK_FLAG, 1);
        FRAME_SYNC_DETECT <= 1'b0;
        repeat (3 * LOCKC) @(posedge MCLK);
        chk("lock held", LOCK_FLAG, 1);
        repeat (10 * LOCKC) @(posedge MCLK);
        chk("lock down", {LOCK_FLAG, WIDE_MODE_LOCK_FLAG}, 0);
        $display("test lock done");
        wrap_up();
    end
endmodule
`default_nettype wire
